// file: asl_consts.svh
/*
  register offsets, field positions, reset values and timing counts
  for the serial line control block. assumes inclusion by bare name.
*/
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH

// register map (word index on the plain register port)
`define ASL_OFF_FMT      3'h0
`define ASL_OFF_CTL      3'h1
`define ASL_OFF_STAT     3'h2
`define ASL_OFF_DATA     3'h3
`define ASL_OFF_NINTH    3'h4
`define ASL_OFF_BAUD     3'h5

// line_format_control fields
`define ASL_FMT_LOOP     7
`define ASL_FMT_ON       6
`define ASL_FMT_FLIP     5
`define ASL_FMT_LEN9     4
`define ASL_FMT_WAKE     3
`define ASL_FMT_IDLE_COUNT_TYPE     2
`define ASL_FMT_PAR      1
`define ASL_FMT_ODD      0

// tx_rx_control fields
`define ASL_CTL_TEIE     7
`define ASL_CTL_TX_DONE_IRQ_EN     6
`define ASL_CTL_RFIE     5
`define ASL_CTL_IDLE_IRQ_EN     4
`define ASL_CTL_TXON     3
`define ASL_CTL_RXON     2
`define ASL_CTL_STBY     1
`define ASL_CTL_BRK      0

// status fields
`define ASL_ST_TEMPTY    7
`define ASL_ST_TDONE     6
`define ASL_ST_RFULL     5
`define ASL_ST_IDLE      4
`define ASL_ST_OVR       3
`define ASL_ST_FERR      1
`define ASL_ST_PERR      0

// reset values
`define ASL_FMT_RST      8'h00
`define ASL_CTL_RST      8'h00
`define ASL_BAUD_RST     8'h03

// bits per frame (short and long) and oversample per bit
`define ASL_BITS_8       4'ha
`define ASL_BITS_9       4'hb
`define ASL_OVS          5'h10
`define ASL_OVS_MID      5'h08

`endif

// file: asl_pkg.sv
/*
  types for the serial line control block.
  assumes nothing beyond a systemverilog compiler.
*/
package asl_pkg;
  typedef enum logic [1:0] {
    ASL_TX_IDLE  = 2'b00,
    ASL_TX_PRE   = 2'b01,
    ASL_TX_DATA  = 2'b10,
    ASL_TX_BREAK = 2'b11
  } asl_tx_e;
  typedef logic [7:0] asl_byte_t;
endpackage

// file: asl_serial_ctl.sv
/*
  serial line control: format and tx/rx control registers, a
  transmitter, a simple oversampling receiver and the request outputs.
  assumes a single 40 MHz clock; rx pin is asynchronous and is
  synchronised here; register port reads answer one cycle later.
*/
// Contract
// (R1) loopback disconnects rx pin and feeds tx output into receiver
// (R2) module enable runs baud generator; clearing sets empty/done, masks tx irq
// (R3) polarity flip inverts every transmitted level including idle and break
// (R4) length bit picks 9-bit (11-bit frame) or 8-bit (10-bit frame)
// (R5) parity sits in the character msb when parity is on
// (R6) parity select: 1 odd, 0 even
// (R7) software keeps parity type stable during a character
// (R8) wake method: 1 address mark, 0 idle line
// (R9) idle count starts after stop bit when 1, after start when 0
// (R10) tx requests from empty and done flags each gated by own enable
// (R11) rx requests from full and idle flags each gated by own enable
// (R12) enabling transmitter sends a preamble of 10 or 11 ones
// (R13) disabling transmitter finishes current character, then idles high
// (R14) off then on during a transmission queues one idle character
// (R15) software leaves tx/rx enables alone while module is off
// (R16) rx enable turns receiver on; clearing keeps rx flags
// (R17) standby masks rx requests; hardware clears it on wake event
// (R18) break bit sends break then a one; held sends breaks back to back
// (R19) software waits before toggling break after empty flag sets
// (R20) reset clears every bit of both control registers
// (R21) empty flag sets on hand-off to shift register; reset sets it
// (R22) idle flag sets after 10 or 11 consecutive ones
// (R23) address mark wake clears standby and sets full flag
// (R24) frame: low start, data lsb first, high stop
`timescale 1ns/1ps
`include "asl_consts.svh"
module asl_serial_ctl (
  // clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst,
  // register port
  input  wire logic [2:0]     i_addr,
  input  wire asl_pkg::asl_byte_t i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output logic [7:0]          o_rdata,
  // serial pins
  input  wire logic           i_serial_in_pin,
  output logic                o_serial_out_pin,
  // requests
  output logic                o_tx_irq,
  output logic                o_rx_irq
);
  import asl_pkg::*;

  logic [7:0] fmt_ff, nxt_fmt;
  logic [7:0] ctl_ff, nxt_ctl;
  logic [7:0] baud_ff, nxt_baud;
  logic [7:0] tdat_ff, nxt_tdat;
  logic [7:0] rdat_ff, nxt_rdat;
  logic       t8_ff, nxt_t8;
  logic       r8_ff, nxt_r8;
  logic       temp_ff, nxt_temp;
  logic       tdone_ff, nxt_tdone;
  logic       rfull_ff, nxt_rfull;
  logic       idle_ff, nxt_idle;
  logic       ovr_ff, nxt_ovr;
  logic       ferr_ff, nxt_ferr;
  logic       perr_ff, nxt_perr;
  logic       armed_ff, nxt_armed;
  logic       sread_ff, nxt_sread;
  logic [7:0] rdata_ff, nxt_rdata;

  wire mod_on   = fmt_ff[`ASL_FMT_ON];
  wire loop_sel = fmt_ff[`ASL_FMT_LOOP];
  wire len9     = fmt_ff[`ASL_FMT_LEN9];
  wire par_on   = fmt_ff[`ASL_FMT_PAR];
  wire par_odd  = fmt_ff[`ASL_FMT_ODD];
  wire tx_on    = ctl_ff[`ASL_CTL_TXON];
  wire rx_on    = ctl_ff[`ASL_CTL_RXON];
  wire [3:0] nbits = len9 ? `ASL_BITS_9 : `ASL_BITS_8; // [R4]

  // baud divider: one tick per oversample slot, runs only when on
  logic [7:0] bdiv_ff, nxt_bdiv;
  logic       otick;
  always_comb begin
    otick = 1'b0;
    nxt_bdiv = bdiv_ff;
    if (!mod_on) begin
      nxt_bdiv = 8'h00; // [R2]
    end else if (bdiv_ff == baud_ff) begin
      nxt_bdiv = 8'h00;
      otick = 1'b1;
    end else begin
      nxt_bdiv = bdiv_ff + 8'h01;
    end
  end
  // bit tick every sixteen oversample ticks
  logic [3:0] ovs_ff, nxt_ovs;
  logic       btick;
  always_comb begin
    nxt_ovs = ovs_ff;
    btick = 1'b0;
    if (!mod_on) begin
      nxt_ovs = 4'h0;
    end else if (otick) begin
      nxt_ovs = ovs_ff + 4'h1;
      btick = (ovs_ff == 4'hf);
    end
  end

  // transmitter
  asl_tx_e    txs_ff, nxt_txs;
  logic [10:0] tsh_ff, nxt_tsh;
  logic [3:0] tcnt_ff, nxt_tcnt;
  logic       tline_ff, nxt_tline;
  logic       txon_d_ff, nxt_txon_d;
  logic       qidle_ff, nxt_qidle;
  logic       brkq_ff, nxt_brkq;
  logic       tload;
  logic [8:0] tchar;
  always_comb begin
    // parity replaces the character msb [R5] [R6]
    tchar = {t8_ff, tdat_ff};
    if (par_on && len9) tchar[8] = ^tdat_ff ^ par_odd;
    if (par_on && !len9) tchar[7] = ^tdat_ff[6:0] ^ par_odd;
  end
  always_comb begin
    nxt_txs = txs_ff;
    nxt_tsh = tsh_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tline = tline_ff;
    nxt_txon_d = tx_on;
    nxt_qidle = qidle_ff;
    nxt_brkq = brkq_ff;
    tload = 1'b0;
    // latch a short break pulse, bit ticks are far apart [R18]
    if (ctl_ff[`ASL_CTL_BRK] && tx_on && txs_ff != ASL_TX_BREAK) begin
      nxt_brkq = 1'b1;
    end
    if (!mod_on) begin
      nxt_txs = ASL_TX_IDLE;
      nxt_tline = 1'b1;
      nxt_qidle = 1'b0;
      nxt_brkq = 1'b0;
    end else if (btick) begin
      case (txs_ff)
        ASL_TX_IDLE: begin
          nxt_tline = 1'b1;
          if (tx_on && qidle_ff) begin
            nxt_txs = ASL_TX_PRE; // [R12]
            nxt_tcnt = nbits;
            nxt_qidle = 1'b0;
          end else if (tx_on && brkq_ff) begin
            nxt_txs = ASL_TX_BREAK;
            nxt_tcnt = nbits;
            nxt_tline = 1'b0;
            nxt_brkq = 1'b0;
          end else if (tx_on && !temp_ff) begin
            tload = 1'b1; // [R21]
            nxt_txs = ASL_TX_DATA;
            nxt_tcnt = nbits - 4'h1;
            nxt_tline = 1'b0; // start bit low [R24]
            nxt_tsh = len9 ? {1'b1, tchar, 1'b1}
                           : {2'b11, tchar[7:0], 1'b1};
          end
        end
        ASL_TX_PRE: begin
          nxt_tline = 1'b1;
          nxt_tcnt = tcnt_ff - 4'h1;
          if (tcnt_ff == 4'h1) nxt_txs = ASL_TX_IDLE;
        end
        ASL_TX_DATA: begin
          nxt_tsh = {1'b1, tsh_ff[10:1]};
          nxt_tline = tsh_ff[1]; // lsb first, stop high [R24]
          nxt_tcnt = tcnt_ff - 4'h1;
          if (tcnt_ff == 4'h0) begin
            // finish the character even if disabled [R13]
            nxt_tline = 1'b1;
            nxt_txs = qidle_ff ? ASL_TX_PRE : ASL_TX_IDLE;
            nxt_tcnt = nbits;
            nxt_qidle = 1'b0;
          end
        end
        ASL_TX_BREAK: begin
          nxt_tcnt = tcnt_ff - 4'h1;
          nxt_tline = 1'b0;
          if (tcnt_ff == 4'h1) begin
            // held bit chains breaks; release sends a one [R18]
            if (ctl_ff[`ASL_CTL_BRK] && tx_on) begin
              nxt_tcnt = nbits;
            end else begin
              nxt_txs = ASL_TX_IDLE;
              nxt_tline = 1'b1;
            end
          end
        end
        default: nxt_txs = ASL_TX_IDLE;
      endcase
    end
    // each enable edge owes a preamble, queued if busy [R12] [R14]
    if (mod_on && tx_on && !txon_d_ff && nxt_txs != ASL_TX_PRE) begin
      nxt_qidle = 1'b1;
    end
  end

  // rx pin synchroniser; first stage feeds only the second
  logic rxs1_ff, rxs2_ff;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rxs1_ff <= 1'b1;
      rxs2_ff <= 1'b1;
    end else begin
      rxs1_ff <= i_serial_in_pin;
      rxs2_ff <= rxs1_ff;
    end
  end
  // loopback takes the unflipped tx line [R1]
  wire rx_line = (loop_sel && tx_on && rx_on) ? tline_ff : rxs2_ff;

  // receiver: start detect, mid-bit sampling, idle counting
  logic       rbusy_ff, nxt_rbusy;
  logic [4:0] rph_ff, nxt_rph;
  logic [3:0] rcnt_ff, nxt_rcnt;
  logic [9:0] rsh_ff, nxt_rsh;
  logic [3:0] ones_ff, nxt_ones;
  logic       rdone, rsamp, idle_hit;
  always_comb begin
    nxt_rbusy = rbusy_ff;
    nxt_rph = rph_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rsh = rsh_ff;
    nxt_ones = ones_ff;
    rdone = 1'b0;
    rsamp = 1'b0;
    idle_hit = 1'b0;
    if (!rx_on || !mod_on) begin
      nxt_rbusy = 1'b0; // [R16]
      nxt_ones = 4'h0;
    end else if (otick) begin
      if (!rbusy_ff) begin
        if (!rx_line) begin
          nxt_rbusy = 1'b1;
          nxt_rph = 5'h00;
          nxt_rcnt = nbits - 4'h1;
        end
      end else begin
        nxt_rph = rph_ff + 5'h01;
        if (rph_ff == `ASL_OVS_MID) rsamp = 1'b1;
        if (rph_ff == `ASL_OVS - 5'h01) nxt_rph = 5'h00;
      end
      if (rsamp) begin
        nxt_rsh = {rx_line, rsh_ff[9:1]};
        nxt_rcnt = rcnt_ff - 4'h1;
        if (rcnt_ff == 4'h0) begin
          rdone = 1'b1;
          nxt_rbusy = 1'b0;
        end
      end
      // idle counting: after start or after stop [R9] [R22]
      if (rsamp || (!rbusy_ff && ovs_ff == 4'hf)) begin
        if (!rx_line) begin
          nxt_ones = 4'h0;
        end else if (fmt_ff[`ASL_FMT_IDLE_COUNT_TYPE] && rbusy_ff) begin
          nxt_ones = 4'h0;
        end else if (ones_ff != 4'hf) begin
          nxt_ones = ones_ff + 4'h1;
        end
        if (ones_ff == nbits - 4'h1 && rx_line) idle_hit = 1'b1;
      end
    end
  end
  // received character sits above the start bit; stop is the live sample
  wire [8:0] rchar = len9 ? rsh_ff[9:1] : {rsh_ff[9], rsh_ff[9:2]};
  wire       rstop = rx_line;
  wire       rmsb  = len9 ? rsh_ff[9] : rsh_ff[9];
  wire       rpar_bad = par_on &&
    (len9 ? (^rsh_ff[9:1] ^ par_odd) : (^rsh_ff[9:2] ^ par_odd)); // [R6]
  wire       standby = ctl_ff[`ASL_CTL_STBY];
  wire       wake_mark = fmt_ff[`ASL_FMT_WAKE];
  wire       am_wake = standby && wake_mark && rdone && rmsb; // [R23]
  wire       id_wake = standby && !wake_mark && idle_hit; // [R8]
  wire       rx_take = rdone && (!standby || am_wake);

  // register writes and flags; hardware set beats software clear
  wire wr_fmt  = i_wr && i_addr == `ASL_OFF_FMT;
  wire wr_ctl  = i_wr && i_addr == `ASL_OFF_CTL;
  wire wr_dat  = i_wr && i_addr == `ASL_OFF_DATA;
  wire rd_stat = i_rd && i_addr == `ASL_OFF_STAT;
  wire rd_dat  = i_rd && i_addr == `ASL_OFF_DATA;
  wire tx_busy = txs_ff != ASL_TX_IDLE;
  always_comb begin
    nxt_fmt = wr_fmt ? i_wdata : fmt_ff;
    nxt_ctl = wr_ctl ? i_wdata : ctl_ff;
    if (id_wake || am_wake) nxt_ctl[`ASL_CTL_STBY] = 1'b0; // [R17]
    nxt_baud = (i_wr && i_addr == `ASL_OFF_BAUD) ? i_wdata : baud_ff;
    nxt_t8 = (i_wr && i_addr == `ASL_OFF_NINTH) ? i_wdata[6] : t8_ff;
    nxt_tdat = wr_dat ? i_wdata : tdat_ff;
    nxt_temp = temp_ff;
    if (wr_dat && sread_ff) nxt_temp = 1'b0;
    if (tload || !mod_on) nxt_temp = 1'b1; // [R2] [R21]
    nxt_tdone = temp_ff && !tx_busy && !tload;
    if (!mod_on) nxt_tdone = 1'b1; // [R2]
    nxt_sread = rd_stat ? 1'b1 : ((wr_dat || rd_dat) ? 1'b0 : sread_ff);
    nxt_rdat = rdat_ff;
    nxt_r8 = r8_ff;
    nxt_rfull = rfull_ff;
    nxt_ovr = ovr_ff;
    nxt_ferr = ferr_ff;
    nxt_perr = perr_ff;
    nxt_idle = idle_ff;
    nxt_armed = armed_ff;
    if (rd_dat && sread_ff) begin
      nxt_rfull = 1'b0;
      nxt_ovr = 1'b0;
      nxt_ferr = 1'b0;
      nxt_perr = 1'b0;
      if (idle_ff) nxt_armed = 1'b0;
      nxt_idle = 1'b0;
    end
    if (rx_take) begin
      if (rfull_ff && !(rd_dat && sread_ff)) begin
        nxt_ovr = 1'b1;
      end else begin
        nxt_rdat = rchar[7:0];
        nxt_r8 = rchar[8];
        nxt_rfull = 1'b1;
        nxt_ferr = !rstop;
        nxt_perr = rpar_bad;
      end
      nxt_armed = 1'b1;
    end
    if (idle_hit && armed_ff && !id_wake) nxt_idle = 1'b1; // [R22]
  end

  // read mux, answer one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ASL_OFF_FMT:   nxt_rdata = fmt_ff;
        `ASL_OFF_CTL:   nxt_rdata = ctl_ff;
        `ASL_OFF_STAT:  nxt_rdata = {temp_ff, tdone_ff, rfull_ff, idle_ff,
                                     ovr_ff, 1'b0, ferr_ff, perr_ff};
        `ASL_OFF_DATA:  nxt_rdata = rdat_ff;
        `ASL_OFF_NINTH: nxt_rdata = {r8_ff, t8_ff, 6'h00};
        `ASL_OFF_BAUD:  nxt_rdata = baud_ff;
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  // request and pin outputs, registered
  logic txirq_ff, rxirq_ff, pin_ff;
  wire nxt_txirq = mod_on && ((temp_ff && ctl_ff[`ASL_CTL_TEIE]) ||
                   (tdone_ff && ctl_ff[`ASL_CTL_TX_DONE_IRQ_EN])); // [R10] [R2]
  wire nxt_rxirq = !standby && ((rfull_ff && ctl_ff[`ASL_CTL_RFIE]) ||
                   (idle_ff && ctl_ff[`ASL_CTL_IDLE_IRQ_EN])); // [R11] [R17]
  wire nxt_pin = tline_ff ^ fmt_ff[`ASL_FMT_FLIP]; // [R3]

  // all state registers except the rx pin synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fmt_ff <= `ASL_FMT_RST; // [R20]
      ctl_ff <= `ASL_CTL_RST; // [R20]
      baud_ff <= `ASL_BAUD_RST;
      bdiv_ff <= 8'h00;
      ovs_ff <= 4'h0;
      tdat_ff <= 8'h00;
      rdat_ff <= 8'h00;
      t8_ff <= 1'b0;
      r8_ff <= 1'b0;
      temp_ff <= 1'b1; // [R21]
      tdone_ff <= 1'b1;
      rfull_ff <= 1'b0;
      idle_ff <= 1'b0;
      ovr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      perr_ff <= 1'b0;
      armed_ff <= 1'b0;
      sread_ff <= 1'b0;
      rdata_ff <= 8'h00;
      txs_ff <= ASL_TX_IDLE;
      tsh_ff <= 11'h7ff;
      tcnt_ff <= 4'h0;
      tline_ff <= 1'b1;
      txon_d_ff <= 1'b0;
      qidle_ff <= 1'b0;
      brkq_ff <= 1'b0;
      rbusy_ff <= 1'b0;
      rph_ff <= 5'h00;
      rcnt_ff <= 4'h0;
      rsh_ff <= 10'h000;
      ones_ff <= 4'h0;
      txirq_ff <= 1'b0;
      rxirq_ff <= 1'b0;
      pin_ff <= 1'b1;
    end else begin
      fmt_ff <= nxt_fmt;
      ctl_ff <= nxt_ctl;
      baud_ff <= nxt_baud;
      bdiv_ff <= nxt_bdiv;
      ovs_ff <= nxt_ovs;
      tdat_ff <= nxt_tdat;
      rdat_ff <= nxt_rdat;
      t8_ff <= nxt_t8;
      r8_ff <= nxt_r8;
      temp_ff <= nxt_temp;
      tdone_ff <= nxt_tdone;
      rfull_ff <= nxt_rfull;
      idle_ff <= nxt_idle;
      ovr_ff <= nxt_ovr;
      ferr_ff <= nxt_ferr;
      perr_ff <= nxt_perr;
      armed_ff <= nxt_armed;
      sread_ff <= nxt_sread;
      rdata_ff <= nxt_rdata;
      txs_ff <= nxt_txs;
      tsh_ff <= nxt_tsh;
      tcnt_ff <= nxt_tcnt;
      tline_ff <= nxt_tline;
      txon_d_ff <= nxt_txon_d;
      qidle_ff <= nxt_qidle;
      brkq_ff <= nxt_brkq;
      rbusy_ff <= nxt_rbusy;
      rph_ff <= nxt_rph;
      rcnt_ff <= nxt_rcnt;
      rsh_ff <= nxt_rsh;
      ones_ff <= nxt_ones;
      txirq_ff <= nxt_txirq;
      rxirq_ff <= nxt_rxirq;
      pin_ff <= nxt_pin;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_serial_out_pin = pin_ff;
  assign o_tx_irq = txirq_ff;
  assign o_rx_irq = rxirq_ff;
endmodule

// file: asl_serial_ctl_properties.sv
/*
  concurrent checks on the serial line control ports.
  assumes a bind onto asl_serial_ctl and one clock domain.
*/
`timescale 1ns/1ps
module asl_serial_ctl_props (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst,
  // register port
  input  wire logic [2:0]         i_addr,
  input  wire asl_pkg::asl_byte_t i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  input  wire logic [7:0]         o_rdata,
  // pins and requests
  input  wire logic               i_serial_in_pin,
  input  wire logic               o_serial_out_pin,
  input  wire logic               o_tx_irq,
  input  wire logic               o_rx_irq
);
  import asl_pkg::*;
  logic [7:0] fmt_ff;
  logic [7:0] nxt_fmt;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic       used_ff;
  logic       nxt_used;

  // shadow of both control registers; standby is cleared by hardware
  always_comb begin
    nxt_fmt  = fmt_ff;
    nxt_ctl  = ctl_ff;
    nxt_used = used_ff;
    if (i_wr && i_addr == 3'h0) begin
      nxt_fmt = i_wdata;
    end
    if (i_wr && i_addr == 3'h1) begin
      nxt_ctl  = i_wdata;
      nxt_used = used_ff | i_wdata[3] | i_wdata[0];
    end
  end

  // shadow registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fmt_ff  <= 8'h00;
      ctl_ff  <= 8'h00;
      used_ff <= 1'b0;
    end else begin
      fmt_ff  <= nxt_fmt;
      ctl_ff  <= nxt_ctl;
      used_ff <= nxt_used;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  fmt_readback_a: assert property (
    i_rd && i_addr == 3'h0 |=> o_rdata == fmt_ff)
    else $error("format register readback differs");
  ctl_readback_a: assert property (
    i_rd && i_addr == 3'h1 |=> (o_rdata & 8'hfd) == (ctl_ff & 8'hfd))
    else $error("control register readback differs");
  tx_irq_off_a: assert property (
    !fmt_ff[6] && !$past(fmt_ff[6]) |-> !o_tx_irq)
    else $error("tx request while module off");
  tx_irq_mask_a: assert property (
    ctl_ff[7:6] == 2'b00 && $past(ctl_ff[7:6]) == 2'b00 |-> !o_tx_irq)
    else $error("tx request with both enables clear");
  rx_irq_mask_a: assert property (
    ctl_ff[5:4] == 2'b00 && $past(ctl_ff[5:4]) == 2'b00 |-> !o_rx_irq)
    else $error("rx request with both enables clear");
  idle_level_a: assert property (
    !used_ff && fmt_ff[5] == $past(fmt_ff[5])
    |-> o_serial_out_pin == !fmt_ff[5])
    else $error("idle level wrong for polarity");
  start_bit_a: assert property (
    $fell(o_serial_out_pin) && !fmt_ff[5] && !$past(fmt_ff[5])
    |-> !o_serial_out_pin [*8])
    else $error("low bit shorter than half a bit time");
  rdata_quiet_a: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  unmapped_read_a: assert property (
    i_rd && i_addr > 3'h5 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  cover property (i_rd && i_addr == 3'h3);
  cover property ($rose(o_tx_irq));
  cover property ($rose(o_rx_irq));
endmodule

// file: asl_far_node.sv
/*
  remote serial node: decodes frames off the line and sends frames.
  assumes a non-inverted line view and a fixed bit length in clocks.
*/
`timescale 1ns/1ps
module asl_far_node #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  int         n_frames = 0;
  int         nbits    = 8;
  logic [8:0] got      = 9'h000;
  logic       stop_bit = 1'b1;

  initial begin
    o_line = 1'b1;
  end

  // decode: low start, lsb first, stop sampled mid bit
  initial forever begin
    @(posedge i_clk iff !i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    if (!i_line) begin
      got = 9'h000;
      for (int k = 0; k < nbits; k++) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        got[k] = i_line;
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      stop_bit = i_line;
      n_frames++;
      // a break has no stop, so wait for the line to rise again
      @(posedge i_clk iff i_line);
    end
  end

  // send one frame, then leave the line at idle high
  task automatic send(input logic [8:0] d, input int n);
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (int k = 0; k < n; k++) begin
      o_line <= d[k];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask
endmodule

// file: tb_top.sv
/*
  self-checking bench for the serial line control block.
  assumes the far node model; baud divider is set to 0 (16 clk bits).
*/
`timescale 1ns/1ps
module tb_top;
  import asl_pkg::*;
  typedef struct {
    logic [7:0] fmt;
    logic [7:0] d;
    logic       t8;
    logic [8:0] e;
  } asl_row_s;
  logic       sys_clk;
  logic       rst      = 1'b1;
  logic [2:0] addr     = 3'h0;
  asl_byte_t  wdata    = 8'h00;
  logic       wr       = 1'b0;
  logic       rd       = 1'b0;
  logic       inv      = 1'b0;
  logic       hold_low = 1'b0;
  logic [7:0] rdata;
  logic       sout;
  logic       tx_irq;
  logic       rx_irq;
  logic       far_line;
  wire logic  sin = hold_low ? 1'b0 : far_line;
  int         mismatches = 0;
  int         n_tests    = 0;
  // format, data, ninth bit, bits seen on the line
  asl_row_s   rows [7] = '{'{8'h40, 8'ha5, 1'b0, 9'h0a5},
    '{8'h50, 8'h3c, 1'b1, 9'h13c}, '{8'h42, 8'h83, 1'b0, 9'h003},
    '{8'h43, 8'h03, 1'b0, 9'h083}, '{8'h52, 8'h01, 1'b0, 9'h101},
    '{8'h53, 8'hff, 1'b0, 9'h1ff}, '{8'h60, 8'h5a, 1'b0, 9'h05a}};

  asl_serial_ctl DUT (
    .i_sys_clk        (sys_clk),
    .i_rst            (rst),
    .i_addr           (addr),
    .i_wdata          (wdata),
    .i_wr             (wr),
    .i_rd             (rd),
    .o_rdata          (rdata),
    .i_serial_in_pin  (sin),
    .o_serial_out_pin (sout),
    .o_tx_irq         (tx_irq),
    .o_rx_irq         (rx_irq)
  );
  asl_far_node #(.BIT_CLKS(16)) u_far (
    .i_clk  (sys_clk),
    .i_line (sout ^ inv),
    .o_line (far_line)
  );

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // strobe then one quiet edge, so no strobe is set twice in a step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input string nm, input logic [2:0] a,
                        input logic [7:0] e, input logic [7:0] m);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(nm, 9'(e), 9'(rdata & m));
    @(posedge sys_clk);
  endtask

  task automatic hold_hi(input int n);
    logic ok = 1'b1;
    repeat (n) begin
      @(posedge sys_clk);
      ok &= ((sout ^ inv) === 1'b1);
    end
    chk("line_high", 9'h001, 9'(ok));
  endtask

  task automatic wait_frame(input int n0);
    int k = 0;
    while (u_far.n_frames == n0 && k < 600) begin
      @(posedge sys_clk);
      k++;
    end
    chk("frame_seen", 9'h001, 9'(u_far.n_frames != n0));
  endtask

  // hand one character over; cut drops the transmitter at start bit
  task automatic send_tx(input logic [7:0] d, input logic t8,
                         input logic cut);
    int n0;
    int k = 0;
    rd_chk("tx_empty", 3'h2, 8'h80, 8'h80);
    wr_reg(3'h4, {1'b0, t8, 6'h00});
    n0 = u_far.n_frames;
    wr_reg(3'h3, d);
    while (cut && (sout ^ inv) && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    if (cut) wr_reg(3'h1, 8'h00);
    wait_frame(n0);
  endtask

  task automatic rx_frame(input logic [8:0] d);
    u_far.send(d, 8);
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, well past the few thousand cycles the tests take
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    int n0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk("fmt_rst", 3'h0, 8'h00, 8'hff);
    rd_chk("ctl_rst", 3'h1, 8'h00, 8'hff);
    rd_chk("stat_rst", 3'h2, 8'hc0, 8'hff);
    rd_chk("baud_rst", 3'h5, 8'h03, 8'hff);
    wr_reg(3'h7, 8'hff);
    rd_chk("unmapped", 3'h7, 8'h00, 8'hff);
    wr_reg(3'h5, 8'h00);
    // format only changes with the transmitter off
    foreach (rows[i]) begin
      wr_reg(3'h0, rows[i].fmt);
      inv <= rows[i].fmt[5];
      u_far.nbits = rows[i].fmt[4] ? 9 : 8;
      wr_reg(3'h1, 8'h08);
      hold_hi(140);
      rd_chk("pre_busy", 3'h2, 8'h80, 8'hc0);
      send_tx(rows[i].d, rows[i].t8, 1'b0);
      chk("tx_data", rows[i].e, u_far.got);
      chk("tx_stop", 9'h001, 9'(u_far.stop_bit));
      wr_reg(3'h1, 8'h00);
    end
    // transmit requests and module off
    wr_reg(3'h0, 8'h40);
    inv <= 1'b0;
    wr_reg(3'h1, 8'h80);
    #1 chk("irq_empty", 9'h001, 9'(tx_irq));
    wr_reg(3'h1, 8'h40);
    #1 chk("irq_done", 9'h001, 9'(tx_irq));
    wr_reg(3'h1, 8'h00);
    #1 chk("irq_none", 9'h000, 9'(tx_irq));
    wr_reg(3'h1, 8'hc0);
    wr_reg(3'h0, 8'h00);
    #1 chk("irq_off", 9'h000, 9'(tx_irq));
    rd_chk("stat_off", 3'h2, 8'hc0, 8'hc0);
    // receive, receiver off keeps flags, idle
    wr_reg(3'h0, 8'h40);
    wr_reg(3'h1, 8'h24);
    rx_frame(9'h096);
    #1 chk("rx_irq_full", 9'h001, 9'(rx_irq));
    rd_chk("rx_full", 3'h2, 8'h20, 8'h20);
    wr_reg(3'h1, 8'h20);
    #1 chk("rx_off_keep", 9'h001, 9'(rx_irq));
    rd_chk("rx_data", 3'h3, 8'h96, 8'hff);
    #1 chk("rx_irq_clr", 9'h000, 9'(rx_irq));
    wr_reg(3'h1, 8'h14);
    rx_frame(9'h055);
    repeat (250) @(posedge sys_clk);
    #1 chk("rx_irq_idle", 9'h001, 9'(rx_irq));
    rd_chk("idle_flag", 3'h2, 8'h30, 8'h30);
    rd_chk("idle_data", 3'h3, 8'h55, 8'hff);
    // address mark wake from standby
    wr_reg(3'h0, 8'h48);
    wr_reg(3'h1, 8'h26);
    rx_frame(9'h012);
    #1 chk("stby_quiet", 9'h000, 9'(rx_irq));
    rx_frame(9'h081);
    rd_chk("stby_clr", 3'h1, 8'h24, 8'hff);
    rd_chk("wake_full", 3'h2, 8'h20, 8'h20);
    rd_chk("wake_data", 3'h3, 8'h81, 8'hff);
    // loopback with the outside pin held low
    wr_reg(3'h0, 8'hc0);
    hold_low <= 1'b1;
    wr_reg(3'h1, 8'h2c);
    repeat (200) @(posedge sys_clk);
    rd_chk("lp_empty", 3'h2, 8'h80, 8'h80);
    wr_reg(3'h3, 8'h3c);
    repeat (250) @(posedge sys_clk);
    #1 chk("lp_irq", 9'h001, 9'(rx_irq));
    rd_chk("lp_full", 3'h2, 8'h20, 8'h20);
    rd_chk("lp_data", 3'h3, 8'h3c, 8'hff);
    // transmitter dropped mid character, then one break
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h0, 8'h40);
    hold_low <= 1'b0;
    wr_reg(3'h1, 8'h08);
    hold_hi(140);
    send_tx(8'hc3, 1'b0, 1'b1);
    chk("cut_data", 9'h0c3, u_far.got);
    wr_reg(3'h1, 8'h08);
    repeat (200) @(posedge sys_clk);
    n0 = u_far.n_frames;
    wr_reg(3'h1, 8'h09);
    wr_reg(3'h1, 8'h08);
    wait_frame(n0);
    chk("brk_data", 9'h000, u_far.got);
    chk("brk_stop", 9'h000, 9'(u_far.stop_bit));
    report_and_stop();
  end
endmodule

bind asl_serial_ctl asl_serial_ctl_props u_props (
  .i_sys_clk        (i_sys_clk),
  .i_rst            (i_rst),
  .i_addr           (i_addr),
  .i_wdata          (i_wdata),
  .i_wr             (i_wr),
  .i_rd             (i_rd),
  .o_rdata          (o_rdata),
  .i_serial_in_pin  (i_serial_in_pin),
  .o_serial_out_pin (o_serial_out_pin),
  .o_tx_irq         (o_tx_irq),
  .o_rx_irq         (o_rx_irq)
);
